// >>> shared/gray_pwm_pkg.sv
package gray_pwm_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned COLUMNS    = 32;
	localparam int unsigned GRAY_W     = 8;
	localparam int unsigned IDX_W      = 5;
	localparam logic [7:0]  CNT_TOP    = 8'hFF;
	localparam logic [7:0]  CNT_BOTTOM = 8'h01;
	localparam logic [7:0]  GRAY_OFF   = 8'h00;
	localparam logic [4:0]  IDX_LAST   = 5'h1F;
	localparam logic [4:0]  IDX_RESET  = 5'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned LCD_NS        = 100;
	localparam int unsigned CDD_NS        = 500;
	localparam int unsigned LCW_NS        = 75;
	localparam int unsigned HALF_LINK_NS  = 80;
	localparam int unsigned LCD_CYC  = (LCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CDD_CYC  = (CDD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LCW_CYC  = (LCW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HALF_CYC = (HALF_LINK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0]  WAIT_RESET = 6'h00;

endpackage : gray_pwm_pkg

// >>> shared/gray_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gray_link_if;
	logic [7:0] gray_value_bus;
	logic       shift_clock;
	logic       count_clock;
	logic       chip_select_in;
	logic       load_count;
	logic       blank;
	logic       chip_select_out;

	modport driver (
		input  chip_select_out,
		output gray_value_bus, shift_clock, count_clock, chip_select_in, load_count, blank
	);
	modport controller (
		output chip_select_out,
		input  gray_value_bus, shift_clock, count_clock, chip_select_in, load_count, blank
	);
endinterface : gray_link_if
`default_nettype wire

// >>> rtl/gray_column_driver.sv
// Function
// - Latch one word per shift edge
// - First word feeds column 1, onward
// - Bus bit 7 is value MSB
// - Counter steps on both count edges
// - Match during down-count turns column on
// - Count down to one, then up
// - Second match turns column off
// - Up-count at all ones ends cycle
// - Zero value never pulses
// - Blank presets counter, clears outputs
// - Words accepted only with chip select
// - Chip select out enables next device
// - Counting starts only after load pulse
// - Controller waits 100 ns after load
// - Controller pauses 500 ns at turnaround
// - Link clocks at most 8 MHz
`timescale 1ns/1ps
`default_nettype none
module gray_column_driver (
	// System
	input  wire logic         i_clock,
	input  wire logic         i_resetn,
	// Link
	gray_link_if.controller   link,
	// Columns
	output logic [31:0]       o_column_pulse_out
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree.
	logic [2:0] sck_ff, cck_ff, csi_ff, ld_ff, blk_ff;
	logic [7:0] d1_ff, d2_ff, d3_ff;
	logic       sck_q_ff, cck_q_ff;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			sck_ff <= 3'h0;
			cck_ff <= 3'h0;
			csi_ff <= 3'h0;
			ld_ff  <= 3'h0;
			blk_ff <= 3'h0;
			d1_ff  <= 8'h00;
			d2_ff  <= 8'h00;
			d3_ff  <= 8'h00;
		end else begin
			sck_ff <= {sck_ff[1:0], link.shift_clock};
			cck_ff <= {cck_ff[1:0], link.count_clock};
			csi_ff <= {csi_ff[1:0], link.chip_select_in};
			ld_ff  <= {ld_ff[1:0], link.load_count};
			blk_ff <= {blk_ff[1:0], link.blank};
			d1_ff  <= link.gray_value_bus;
			d2_ff  <= d1_ff;
			d3_ff  <= d2_ff;
		end
	end

	// Filtered levels follow only when the last two stages agree.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			sck_q_ff <= 1'b0;
			cck_q_ff <= 1'b0;
		end else begin
			if (sck_ff[1] == sck_ff[2])
				sck_q_ff <= sck_ff[2];
			if (cck_ff[1] == cck_ff[2])
				cck_q_ff <= cck_ff[2];
		end
	end

	logic sck_edge, cck_edge, csi, ld, blk;
	assign sck_edge = (sck_ff[1] == sck_ff[2]) && (sck_ff[2] != sck_q_ff);
	assign cck_edge = (cck_ff[1] == cck_ff[2]) && (cck_ff[2] != cck_q_ff);
	assign csi = csi_ff[2];
	assign ld  = ld_ff[2];
	assign blk = blk_ff[2];

	// ----------------------------------------------------------------
	// Data latches
	// ----------------------------------------------------------------
	// Data is sampled from the delayed copy so it lines up with the edge.
	logic [7:0] gray_ff [32];
	logic [4:0] idx_ff;
	logic       full_ff;
	logic       cso_ff;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			idx_ff  <= gray_pwm_pkg::IDX_RESET;
			full_ff <= 1'b0;
			cso_ff  <= 1'b0;
		end else if (!csi) begin
			idx_ff  <= gray_pwm_pkg::IDX_RESET;
			full_ff <= 1'b0;
			cso_ff  <= 1'b0;
		end else if (sck_edge && !full_ff) begin
			idx_ff <= idx_ff + 5'h01;
			if (idx_ff == gray_pwm_pkg::IDX_LAST) begin
				full_ff <= 1'b1;
				cso_ff  <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			for (int i = 0; i < 32; i++)
				gray_ff[i] <= gray_pwm_pkg::GRAY_OFF;
		end else if (csi && sck_edge && !full_ff) begin
			gray_ff[idx_ff] <= d3_ff;
		end
	end

	// ----------------------------------------------------------------
	// Master counter
	// ----------------------------------------------------------------
	typedef enum {S_IDLE, S_DOWN, S_UP} cnt_state_type;
	cnt_state_type state_ff;
	logic [7:0]    cnt_ff;

	always_ff @(posedge i_clock) begin
		if (!i_resetn || blk) begin
			state_ff <= S_IDLE;
			cnt_ff   <= gray_pwm_pkg::CNT_TOP;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (ld) begin
						state_ff <= S_DOWN;
						cnt_ff   <= gray_pwm_pkg::CNT_TOP;
					end
				end
				S_DOWN: begin
					if (cck_edge) begin
						if (cnt_ff == gray_pwm_pkg::CNT_BOTTOM) begin
							state_ff <= S_UP;
							cnt_ff   <= cnt_ff + 8'h01;
						end else begin
							cnt_ff <= cnt_ff - 8'h01;
						end
					end
				end
				S_UP: begin
					if (cck_edge) begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff + 8'h01 == gray_pwm_pkg::CNT_TOP)
							state_ff <= S_IDLE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Column outputs
	// ----------------------------------------------------------------
	// Columns react to the value the counter reaches at a count edge.
	// Value one is reached only once, so it ends as the counter leaves it upward.
	// Without that, a column at one would stay on into the next frame.
	logic        active;
	logic        step_up;
	logic [7:0]  step_val;
	logic        frame_go;
	logic [31:0] turn_on;
	logic [31:0] turn_off;

	assign active   = (state_ff != S_IDLE);
	assign step_up  = (state_ff == S_UP) || (cnt_ff == gray_pwm_pkg::CNT_BOTTOM);
	assign step_val = step_up ? (cnt_ff + 8'h01) : (cnt_ff - 8'h01);
	assign frame_go = (state_ff == S_IDLE) && ld;

	always_comb begin
		turn_on  = 32'h0000_0000;
		turn_off = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			if (frame_go && gray_ff[i] == gray_pwm_pkg::CNT_TOP)
				turn_on[i] = 1'b1;
			if (active && cck_edge && !step_up && gray_ff[i] == step_val)
				turn_on[i] = 1'b1;
			if (active && cck_edge && step_up && gray_ff[i] == step_val)
				turn_off[i] = 1'b1;
			if (active && cck_edge && step_up && gray_ff[i] == cnt_ff
					&& cnt_ff == gray_pwm_pkg::CNT_BOTTOM)
				turn_off[i] = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn || blk) begin
			o_column_pulse_out <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 32; i++) begin
				if (gray_ff[i] == gray_pwm_pkg::GRAY_OFF)
					o_column_pulse_out[i] <= 1'b0;
				else if (turn_off[i])
					o_column_pulse_out[i] <= 1'b0;
				else if (turn_on[i])
					o_column_pulse_out[i] <= 1'b1;
			end
		end
	end

	assign link.chip_select_out = cso_ff;

endmodule : gray_column_driver
`default_nettype wire

// >>> rtl/gray_display_controller.sv
`timescale 1ns/1ps
`default_nettype none
module gray_display_controller (
	// System
	input  wire logic        i_clock,
	input  wire logic        i_resetn,
	// User
	input  wire logic        i_load_valid,
	input  wire logic [7:0]  i_load_word,
	input  wire logic        i_load_last,
	output logic             o_load_ready,
	input  wire logic        i_frame_start,
	input  wire logic        i_blank,
	output logic             o_busy,
	output logic             o_next_enabled,
	// Link
	gray_link_if.driver      link
);

	// ----------------------------------------------------------------
	// Controller sequencer
	// ----------------------------------------------------------------
	// A link clock half period is HALF_CYC plus one system cycles, inside the rate limit.
	typedef enum {C_IDLE, C_SHIFT, C_LOAD, C_LCD, C_DOWN, C_PAUSE, C_UP} ctl_state_type;
	ctl_state_type state_ff;
	logic [5:0]    wait_ff;
	logic [8:0]    edges_ff;
	logic [7:0]    data_ff;
	logic          sck_ff, cck_ff, cs_ff, ld_ff, blk_ff, rdy_ff, last_ff, chain_ff, busy_ff;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_ff <= C_IDLE;
			wait_ff  <= gray_pwm_pkg::WAIT_RESET;
			edges_ff <= 9'h000;
			data_ff  <= 8'h00;
			sck_ff   <= 1'b0;
			cck_ff   <= 1'b0;
			cs_ff    <= 1'b0;
			ld_ff    <= 1'b0;
			rdy_ff   <= 1'b0;
			last_ff  <= 1'b0;
		end else begin
			rdy_ff <= 1'b0;
			if (wait_ff != gray_pwm_pkg::WAIT_RESET)
				wait_ff <= wait_ff - 6'h01;
			case (state_ff)
				C_IDLE: begin
					ld_ff <= 1'b0;
					// Select is held past the last shift edge so the driver still takes it.
					if (last_ff && wait_ff == gray_pwm_pkg::WAIT_RESET) begin
						cs_ff   <= 1'b0;
						last_ff <= 1'b0;
					end
					if (i_frame_start) begin
						state_ff <= C_LOAD;
						ld_ff    <= 1'b1;
						wait_ff  <= 6'(gray_pwm_pkg::LCW_CYC + 3);
					end else if (i_load_valid && !last_ff
							&& wait_ff == gray_pwm_pkg::WAIT_RESET) begin
						state_ff <= C_SHIFT;
						cs_ff    <= 1'b1;
						data_ff  <= i_load_word;
						last_ff  <= i_load_last;
						rdy_ff   <= 1'b1;
						wait_ff  <= 6'(gray_pwm_pkg::HALF_CYC);
					end
				end
				C_SHIFT: begin
					if (wait_ff == gray_pwm_pkg::WAIT_RESET) begin
						sck_ff   <= ~sck_ff;
						state_ff <= C_IDLE;
						wait_ff  <= 6'(gray_pwm_pkg::HALF_CYC);
					end
				end
				C_LOAD: begin
					if (wait_ff == gray_pwm_pkg::WAIT_RESET) begin
						ld_ff    <= 1'b0;
						state_ff <= C_LCD;
						wait_ff  <= 6'(gray_pwm_pkg::LCD_CYC + 3);
					end
				end
				C_LCD: begin
					if (wait_ff == gray_pwm_pkg::WAIT_RESET) begin
						state_ff <= C_DOWN;
						edges_ff <= 9'h000;
					end
				end
				C_DOWN, C_UP: begin
					if (wait_ff == gray_pwm_pkg::WAIT_RESET) begin
						cck_ff   <= ~cck_ff;
						edges_ff <= edges_ff + 9'h001;
						wait_ff  <= 6'(gray_pwm_pkg::HALF_CYC);
						if (state_ff == C_DOWN && edges_ff == 9'h0FD)
							state_ff <= C_PAUSE;
						else if (state_ff == C_UP && edges_ff == 9'h0FD)
							state_ff <= C_IDLE;
					end
				end
				C_PAUSE: begin
					edges_ff <= 9'h000;
					wait_ff  <= 6'(gray_pwm_pkg::CDD_CYC + 3);
					state_ff <= C_UP;
				end
				default: state_ff <= C_IDLE;
			endcase
		end
	end

	// Down phase is 254 edges (FF to 01), up phase 254 edges (01 to FF).
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			blk_ff   <= 1'b0;
			chain_ff <= 1'b0;
			busy_ff  <= 1'b0;
		end else begin
			blk_ff   <= i_blank;
			chain_ff <= link.chip_select_out;
			busy_ff  <= (state_ff != C_IDLE);
		end
	end

	assign o_load_ready        = rdy_ff;
	assign o_busy              = busy_ff;
	assign o_next_enabled      = chain_ff;
	assign link.gray_value_bus = data_ff;
	assign link.shift_clock    = sck_ff;
	assign link.count_clock    = cck_ff;
	assign link.chip_select_in = cs_ff;
	assign link.load_count     = ld_ff;
	assign link.blank          = blk_ff;

endmodule : gray_display_controller
`default_nettype wire

// >>> verif/gray_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gray_link_sva (
	// System
	input wire logic       i_clock,
	input wire logic       i_resetn,
	// Link
	input wire logic [7:0] gray_value_bus,
	input wire logic       shift_clock,
	input wire logic       count_clock,
	input wire logic       chip_select_in,
	input wire logic       load_count,
	input wire logic       blank,
	input wire logic       chip_select_out
);
	// ------------------------------------------------
	// Helper counters
	// ------------------------------------------------
	logic       cc_ff;
	logic       sc_ff;
	logic [8:0] edge_ff;
	logic [5:0] gap_ff;
	logic [5:0] word_ff;
	wire        cc_chg = count_clock != cc_ff;
	wire        sc_chg = shift_clock != sc_ff;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	always_ff @(posedge i_clock) begin
		cc_ff <= count_clock;
		sc_ff <= shift_clock;
	end
	// Counts edges of one frame so the turnaround pause can be located.
	always_ff @(posedge i_clock) begin
		if (!i_resetn || load_count) edge_ff <= 9'h000;
		else if (cc_chg) edge_ff <= edge_ff + 9'h001;
	end
	always_ff @(posedge i_clock) begin
		if (!i_resetn || cc_chg) gap_ff <= 6'h01;
		else if (gap_ff != 6'h3F) gap_ff <= gap_ff + 6'h01;
	end
	always_ff @(posedge i_clock) begin
		if (!i_resetn || !chip_select_in) word_ff <= 6'h00;
		else if (sc_chg) word_ff <= word_ff + 6'h01;
	end
	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	property p_shift_rate;
		$changed(shift_clock) |=> $stable(shift_clock)[*3];
	endproperty
	a_shift_rate: assert property (p_shift_rate) else $error("shift clock too fast");
	property p_count_rate;
		$changed(count_clock) |=> $stable(count_clock)[*3];
	endproperty
	a_count_rate: assert property (p_count_rate) else $error("count clock too fast");
	property p_shift_selected;
		$changed(shift_clock) |-> chip_select_in;
	endproperty
	a_shift_selected: assert property (p_shift_selected) else $error("shift unselected");
	property p_data_hold;
		$changed(shift_clock) |-> $stable(gray_value_bus)[*3];
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved at shift");
	property p_load_width;
		$rose(load_count) |=> load_count[*3];
	endproperty
	a_load_width: assert property (p_load_width) else $error("load pulse short");
	property p_load_gap;
		$fell(load_count) |-> $stable(count_clock)[*5];
	endproperty
	a_load_gap: assert property (p_load_gap) else $error("count too soon");
	property p_turnaround;
		cc_chg && edge_ff == 9'd254 |-> gap_ff >= 6'd25;
	endproperty
	a_turnaround: assert property (p_turnaround) else $error("turnaround short");
	property p_words;
		word_ff <= 6'd32;
	endproperty
	a_words: assert property (p_words) else $error("over 32 words");

	c_load: cover property ($rose(load_count));
	c_frame_end: cover property (cc_chg && edge_ff == 9'd507);
	c_chain: cover property ($rose(chip_select_out));
	c_blank: cover property ($rose(blank));
endmodule : gray_link_sva
`default_nettype wire

// >>> verif/gray_shade_column_pwm_driver_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gray_shade_column_pwm_driver_tb_top;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic        i_clock     = 1'b0;
	logic        i_resetn    = 1'b0;
	logic        load_valid  = 1'b0;
	logic [7:0]  load_word   = 8'h00;
	logic        load_last   = 1'b0;
	logic        frame_start = 1'b0;
	logic        blank       = 1'b0;
	logic        load_ready;
	logic        busy;
	logic        next_enabled;
	logic        seen_next   = 1'b0;
	logic        cc_q        = 1'b0;
	logic [31:0] col_q       = 32'h0;
	logic [31:0] pulse_out;
	int          failures    = 0;
	int          check_count = 0;
	int          edge_n      = 0;
	int          rise_at[32];
	int          width[32];
	int          pulses[32];

	gray_link_if link ();
	always #10 i_clock = ~i_clock;

	gray_column_driver u_gray_column_driver (.i_clock(i_clock), .i_resetn(i_resetn),
		.link(link.controller), .o_column_pulse_out(pulse_out));
	gray_display_controller u_gray_display_controller (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_load_valid(load_valid), .i_load_word(load_word), .i_load_last(load_last),
		.o_load_ready(load_ready), .i_frame_start(frame_start), .i_blank(blank),
		.o_busy(busy), .o_next_enabled(next_enabled), .link(link.driver));
	gray_link_sva u_gray_link_sva (.i_clock(i_clock), .i_resetn(i_resetn),
		.gray_value_bus(link.gray_value_bus), .shift_clock(link.shift_clock),
		.count_clock(link.count_clock), .chip_select_in(link.chip_select_in),
		.load_count(link.load_count), .blank(link.blank),
		.chip_select_out(link.chip_select_out));

	// Pulse widths are measured in count edges, so latency of the sync stages cancels out.
	always @(posedge i_clock) begin
		cc_q <= link.count_clock;
		col_q <= pulse_out;
		if (next_enabled === 1'b1) seen_next <= 1'b1;
		if (frame_start) edge_n = 0;
		else if (cc_q !== link.count_clock) edge_n++;
		for (int i = 0; i < 32; i++) begin
			if (pulse_out[i] === 1'b1 && col_q[i] === 1'b0) begin
				rise_at[i] = edge_n;
				pulses[i]++;
			end
			if (pulse_out[i] === 1'b0 && col_q[i] === 1'b1) width[i] = edge_n - rise_at[i];
		end
	end
	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	function automatic logic [7:0] gv(input int i);
		gv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h01 : 8'(i * 8);
	endfunction : gv
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task complete_run;
		$display("Counts: checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic wait_level(ref logic s, input logic lvl);
		for (int k = 0; k < 5000; k++) begin
			@(posedge i_clock);
			if (s === lvl) return;
		end
		failures++;
		complete_run;
	endtask : wait_level
	task send_word(input logic [7:0] w, input logic last);
		load_word <= w;
		load_last <= last;
		load_valid <= 1'b1;
		wait_level(load_ready, 1'b1);
		load_valid <= 1'b0;
		@(posedge i_clock);
	endtask : send_word
	task automatic run_frame(input logic blank_mid);
		int e;
		for (int i = 0; i < 32; i++) begin
			pulses[i] = 0;
			width[i] = -1;
		end
		frame_start <= 1'b1;
		@(posedge i_clock);
		frame_start <= 1'b0;
		repeat (2) @(posedge i_clock);
		if (blank_mid) begin
			repeat (300) @(posedge i_clock);
			check(pulse_out[1], 1);
			blank <= 1'b1;
			repeat (40) @(posedge i_clock);
			check(pulse_out, 0);
			blank <= 1'b0;
			return;
		end
		wait_level(busy, 1'b0);
		repeat (10) @(posedge i_clock);
		for (int i = 0; i < 32; i++) begin
			e = (gv(i) == 8'h01) ? 1 : 2 * gv(i) - 2;
			check(pulses[i], (gv(i) == 8'h00) ? 0 : 1);
			if (gv(i) != 8'h00) check((width[i] >= e - 1 && width[i] <= e + 1) ? e : width[i], e);
		end
	endtask : run_frame

	initial begin
		repeat (3) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clock);
		for (int i = 0; i < 32; i++) send_word(gv(i), i == 31);
		repeat (20) @(posedge i_clock);
		check(seen_next, 1);
		$display("Test load done");
		run_frame(1'b0);
		$display("Test frame done");
		run_frame(1'b0);
		$display("Test repeat frame done");
		run_frame(1'b1);
		$display("Test blank done");
		complete_run;
	end
endmodule : gray_shade_column_pwm_driver_tb_top
`default_nettype wire
